//--- design/lsr_pkg.sv
package lsr_pkg;

  localparam logic [6:0] TARGET_ADDR = 7'h10;

  localparam logic [7:0] CMD_CONF = 8'h00;
  localparam logic [7:0] CMD_THR_HIGH = 8'h01;
  localparam logic [7:0] CMD_THR_LOW = 8'h02;
  localparam logic [7:0] CMD_PSM = 8'h03;
  localparam logic [7:0] CMD_AMBIENT = 8'h04;
  localparam logic [7:0] CMD_WHITE = 8'h05;
  localparam logic [7:0] CMD_STATUS = 8'h06;

  localparam int CONF_SD_BIT = 0;
  localparam int CONF_INT_EN_BIT = 1;
  localparam int CONF_PERS_LSB = 4;
  localparam int CONF_IT_LSB = 6;
  localparam int CONF_GAIN_LSB = 11;
  localparam int POWER_SAVING_ENABLE_BIT = 0;
  localparam int PSM_SEL_LSB = 1;
  localparam int STAT_LOW_BIT = 15;
  localparam int STAT_HIGH_BIT = 14;

  localparam logic [15:0] PSM_MASK = 16'h0007;
  localparam logic [15:0] CONF_RST = 16'h0001;
  localparam logic [15:0] THR_HIGH_RST = 16'hFFFF;
  localparam logic [15:0] THR_LOW_RST = 16'h0000;
  localparam logic [15:0] PSM_RST = 16'h0000;
  localparam logic [15:0] RESULT_RST = 16'h0000;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  typedef struct packed {
    logic [15:0] ambient;
    logic [15:0] white;
  } lsr_sample_s;

  typedef struct packed {
    logic [1:0] gain;
    logic [3:0] integ_time;
    logic [1:0] power_saving_mode_select;
    logic power_saving_enable;
    logic shutdown_control;
  } lsr_ctrl_s;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_ADDR_ACK = 9'h004,
    ST_CMD = 9'h008,
    ST_CMD_ACK = 9'h010,
    ST_WDATA = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA = 9'h080,
    ST_RDATA_ACK = 9'h100
  } lsr_state_e;

endpackage

//--- design/lsr_threshold_check.sv
module lsr_threshold_check (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic sample_valid_in,
  input wire logic [15:0] ambient_in,
  input wire logic [15:0] upper_in,
  input wire logic [15:0] lower_in,
  input wire logic irq_enable_in,
  input wire logic [1:0] persistence_count_in,
  output logic low_hit_out,
  output logic high_hit_out
);

  logic [1:0] exceed;
  logic [1:0] hit;
  logic [3:0] need_m1;

  assign exceed[0] = ambient_in < lower_in;
  assign exceed[1] = ambient_in > upper_in;
  assign need_m1 = (4'h1 << persistence_count_in) - 4'h1;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      logic [3:0] cnt;
      logic [3:0] next_cnt;
      logic next_hit;
      logic fired;

      always_comb begin
        next_cnt = cnt;
        next_hit = 1'b0;
        if (!irq_enable_in) begin
          next_cnt = 4'h0;
        end else if (sample_valid_in) begin
          if (!exceed[g]) begin
            next_cnt = 4'h0;
          // Lowering persistence mid-count must not skip the match
          end else if (cnt >= need_m1) begin
            next_cnt = 4'h0;
            next_hit = 1'b1;
          end else begin
            next_cnt = cnt + 4'h1;
          end
        end
      end

      always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
          cnt <= 4'h0;
          fired <= 1'b0;
        end else begin
          cnt <= next_cnt;
          fired <= next_hit;
        end
      end

      assign hit[g] = fired;
    end
  endgenerate

  assign low_hit_out = hit[0];
  assign high_hit_out = hit[1];

  sequence high_seen;
    irq_enable_in && sample_valid_in && (ambient_in > upper_in);
  endsequence

  sequence low_seen;
    irq_enable_in && sample_valid_in && (ambient_in < lower_in);
  endsequence

  single_high_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    high_seen and (persistence_count_in == 2'h0) |=> high_hit_out)
    else $error("high crossing not flagged at persistence one");

  single_low_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    low_seen and (persistence_count_in == 2'h0) |=> low_hit_out)
    else $error("low crossing not flagged at persistence one");

endmodule

//--- design/lsr_sensor_regs.sv
// How it works
// - Upper threshold word at command 01h
// - Upper threshold high byte 15:8, low 7:0
// - Lower threshold word at command 02h
// - Lower threshold high byte 15:8, low 7:0
// - Power saving bits 2:1 select modes 1-4
// - Power saving bit 0 enables power saving
// - Ambient result read from command 04h
// - Ambient result high byte 15:8, low 7:0
// - White result read from command 05h
// - White result high byte 15:8, low 7:0
// - Status bit 15 flags low crossing
// - Status bit 14 flags high crossing
// - Flags read-only, status bits 13:0 reserved
// - Target answers only at address 10h
// - Flags raised only with interrupt enable set
// - Persistence count 1/2/4/8 before flagging
// - Shutdown keeps last result, refresh after wake
module lsr_sensor_regs (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic sample_valid_in,
  input wire lsr_pkg::lsr_sample_s sample_in,
  output lsr_pkg::lsr_ctrl_s ctrl_out
);

  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  lsr_pkg::lsr_state_e state;
  lsr_pkg::lsr_state_e next_state;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [7:0] rx_sh;
  logic [7:0] next_rx_sh;
  logic [7:0] tx_sh;
  logic [7:0] next_tx_sh;
  logic [7:0] cmd;
  logic [7:0] next_cmd;
  logic [7:0] lo_byte;
  logic [7:0] next_lo_byte;
  logic [15:0] rd_word;
  logic [15:0] next_rd_word;
  logic rw;
  logic next_rw;
  logic byte_idx;
  logic next_byte_idx;
  logic oe;
  logic next_oe;
  logic host_ack;
  logic next_host_ack;
  logic wr_en;
  logic rd_take;
  logic [15:0] wr_word;
  logic [15:0] rd_mux;

  logic [15:0] conf;
  logic [15:0] next_conf;
  logic [15:0] thr_hi;
  logic [15:0] next_thr_hi;
  logic [15:0] thr_lo;
  logic [15:0] next_thr_lo;
  logic [15:0] power_saving_control;
  logic [15:0] next_psm;
  logic [15:0] ambient;
  logic [15:0] next_ambient;
  logic [15:0] white;
  logic [15:0] next_white;
  logic low_flag;
  logic next_low_flag;
  logic high_flag;
  logic next_high_flag;
  logic low_hit;
  logic high_hit;
  logic take_sample;
  logic status_read;

  // Pins are already synchronous, so one stage is enough for edge detection
  assign scl_rise = scl_in && !scl_q;
  assign scl_fall = !scl_in && scl_q;
  assign bus_start = scl_in && scl_q && sda_q && !sda_in;
  assign bus_stop = scl_in && scl_q && !sda_q && sda_in;
  assign wr_word = {rx_sh, lo_byte};

  always_comb begin
    case (cmd)
      lsr_pkg::CMD_CONF: rd_mux = conf;
      lsr_pkg::CMD_THR_HIGH: rd_mux = thr_hi;
      lsr_pkg::CMD_THR_LOW: rd_mux = thr_lo;
      lsr_pkg::CMD_PSM: rd_mux = power_saving_control;
      lsr_pkg::CMD_AMBIENT: rd_mux = ambient;
      lsr_pkg::CMD_WHITE: rd_mux = white;
      lsr_pkg::CMD_STATUS: rd_mux = {low_flag, high_flag, 14'h0000};
      default: rd_mux = 16'h0000;
    endcase
  end

  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_rx_sh = rx_sh;
    next_tx_sh = tx_sh;
    next_cmd = cmd;
    next_lo_byte = lo_byte;
    next_rd_word = rd_word;
    next_rw = rw;
    next_byte_idx = byte_idx;
    next_oe = oe;
    next_host_ack = host_ack;
    wr_en = 1'b0;
    rd_take = 1'b0;
    if (bus_start) begin
      next_state = lsr_pkg::ST_ADDR;
      next_bitcnt = 4'h0;
      next_oe = 1'b0;
    end else if (bus_stop) begin
      next_state = lsr_pkg::ST_IDLE;
      next_oe = 1'b0;
    end else begin
      case (state)
        lsr_pkg::ST_IDLE: begin
          next_oe = 1'b0;
        end
        lsr_pkg::ST_ADDR, lsr_pkg::ST_CMD, lsr_pkg::ST_WDATA: begin
          if (scl_rise) begin
            next_rx_sh = {rx_sh[6:0], sda_in};
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == lsr_pkg::BITS_PER_BYTE) begin
            next_bitcnt = 4'h0;
            if (state == lsr_pkg::ST_ADDR) begin
              if (rx_sh[7:1] == lsr_pkg::TARGET_ADDR) begin
                next_oe = 1'b1;
                next_rw = rx_sh[0];
                next_state = lsr_pkg::ST_ADDR_ACK;
              end else begin
                next_state = lsr_pkg::ST_IDLE;
              end
            end else if (state == lsr_pkg::ST_CMD) begin
              next_cmd = rx_sh;
              next_oe = 1'b1;
              next_state = lsr_pkg::ST_CMD_ACK;
            end else begin
              next_oe = 1'b1;
              next_state = lsr_pkg::ST_WDATA_ACK;
              // Low byte first, word commits on the high byte
              if (byte_idx) begin
                wr_en = 1'b1;
              end else begin
                next_lo_byte = rx_sh;
              end
            end
          end
        end
        lsr_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            next_bitcnt = 4'h0;
            if (rw) begin
              // Whole word latched here so both bytes belong to one sample
              rd_take = 1'b1;
              next_rd_word = rd_mux;
              next_tx_sh = rd_mux[7:0];
              next_oe = !rd_mux[7];
              next_byte_idx = 1'b1;
              next_state = lsr_pkg::ST_RDATA;
            end else begin
              next_oe = 1'b0;
              next_state = lsr_pkg::ST_CMD;
            end
          end
        end
        lsr_pkg::ST_CMD_ACK: begin
          if (scl_fall) begin
            next_oe = 1'b0;
            next_byte_idx = 1'b0;
            next_state = lsr_pkg::ST_WDATA;
          end
        end
        lsr_pkg::ST_WDATA_ACK: begin
          if (scl_fall) begin
            next_oe = 1'b0;
            next_byte_idx = !byte_idx;
            next_state = lsr_pkg::ST_WDATA;
          end
        end
        lsr_pkg::ST_RDATA: begin
          if (scl_fall) begin
            if (bitcnt == lsr_pkg::LAST_BIT) begin
              next_oe = 1'b0;
              next_state = lsr_pkg::ST_RDATA_ACK;
            end else begin
              next_tx_sh = {tx_sh[6:0], 1'b0};
              next_oe = !tx_sh[6];
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        end
        lsr_pkg::ST_RDATA_ACK: begin
          if (scl_rise) begin
            next_host_ack = !sda_in;
          end else if (scl_fall) begin
            if (host_ack) begin
              next_tx_sh = byte_idx ? rd_word[15:8] : rd_word[7:0];
              next_oe = byte_idx ? !rd_word[15] : !rd_word[7];
              next_byte_idx = !byte_idx;
              next_bitcnt = 4'h0;
              next_state = lsr_pkg::ST_RDATA;
            end else begin
              next_state = lsr_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          next_state = lsr_pkg::ST_IDLE;
          next_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      state <= lsr_pkg::ST_IDLE;
      bitcnt <= 4'h0;
      rx_sh <= 8'h00;
      tx_sh <= 8'h00;
      cmd <= 8'h00;
      lo_byte <= 8'h00;
      rd_word <= 16'h0000;
      rw <= 1'b0;
      byte_idx <= 1'b0;
      oe <= 1'b0;
      host_ack <= 1'b0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      state <= next_state;
      bitcnt <= next_bitcnt;
      rx_sh <= next_rx_sh;
      tx_sh <= next_tx_sh;
      cmd <= next_cmd;
      lo_byte <= next_lo_byte;
      rd_word <= next_rd_word;
      rw <= next_rw;
      byte_idx <= next_byte_idx;
      oe <= next_oe;
      host_ack <= next_host_ack;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = oe;

  assign take_sample = sample_valid_in && !conf[lsr_pkg::CONF_SD_BIT];
  assign status_read = rd_take && cmd == lsr_pkg::CMD_STATUS;

  lsr_threshold_check u_check (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .sample_valid_in(take_sample),
    .ambient_in(sample_in.ambient),
    .upper_in(thr_hi),
    .lower_in(thr_lo),
    .irq_enable_in(conf[lsr_pkg::CONF_INT_EN_BIT]),
    .persistence_count_in(conf[lsr_pkg::CONF_PERS_LSB +: 2]),
    .low_hit_out(low_hit),
    .high_hit_out(high_hit)
  );

  always_comb begin
    next_conf = conf;
    next_thr_hi = thr_hi;
    next_thr_lo = thr_lo;
    next_psm = power_saving_control;
    next_ambient = ambient;
    next_white = white;
    if (wr_en) begin
      case (cmd)
        lsr_pkg::CMD_CONF: next_conf = wr_word;
        lsr_pkg::CMD_THR_HIGH: next_thr_hi = wr_word;
        lsr_pkg::CMD_THR_LOW: next_thr_lo = wr_word;
        lsr_pkg::CMD_PSM: next_psm = wr_word & lsr_pkg::PSM_MASK;
        default: next_psm = power_saving_control;
      endcase
    end
    if (take_sample) begin
      next_ambient = sample_in.ambient;
      next_white = sample_in.white;
    end
    // Reading status clears it, but a new crossing in the same cycle wins
    next_low_flag = (low_flag && !status_read) || low_hit;
    next_high_flag = (high_flag && !status_read) || high_hit;
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      conf <= lsr_pkg::CONF_RST;
      thr_hi <= lsr_pkg::THR_HIGH_RST;
      thr_lo <= lsr_pkg::THR_LOW_RST;
      power_saving_control <= lsr_pkg::PSM_RST;
      ambient <= lsr_pkg::RESULT_RST;
      white <= lsr_pkg::RESULT_RST;
      low_flag <= 1'b0;
      high_flag <= 1'b0;
    end else begin
      conf <= next_conf;
      thr_hi <= next_thr_hi;
      thr_lo <= next_thr_lo;
      power_saving_control <= next_psm;
      ambient <= next_ambient;
      white <= next_white;
      low_flag <= next_low_flag;
      high_flag <= next_high_flag;
    end
  end

  assign ctrl_out.gain = conf[lsr_pkg::CONF_GAIN_LSB +: 2];
  assign ctrl_out.integ_time = conf[lsr_pkg::CONF_IT_LSB +: 4];
  assign ctrl_out.power_saving_mode_select = power_saving_control[lsr_pkg::PSM_SEL_LSB +: 2];
  assign ctrl_out.power_saving_enable = power_saving_control[lsr_pkg::POWER_SAVING_ENABLE_BIT];
  assign ctrl_out.shutdown_control = conf[lsr_pkg::CONF_SD_BIT];

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence addr_byte_done;
    state == lsr_pkg::ST_ADDR && scl_fall && !bus_start && !bus_stop && bitcnt == lsr_pkg::BITS_PER_BYTE;
  endsequence

  sequence read_load(logic [7:0] code);
    state == lsr_pkg::ST_ADDR_ACK && scl_fall && !bus_start && !bus_stop && rw && cmd == code;
  endsequence

  addr_ack_a: assert property (addr_byte_done and rx_sh[7:1] == lsr_pkg::TARGET_ADDR
    |=> sda_oe_out && state == lsr_pkg::ST_ADDR_ACK)
    else $error("own address not acknowledged");
  foreign_addr_a: assert property (addr_byte_done and rx_sh[7:1] != lsr_pkg::TARGET_ADDR
    |=> !sda_oe_out && state == lsr_pkg::ST_IDLE)
    else $error("foreign address acknowledged");
  thr_high_wr_a: assert property (wr_en && cmd == lsr_pkg::CMD_THR_HIGH |=> thr_hi == $past(wr_word))
    else $error("upper threshold write lost");
  thr_low_wr_a: assert property (wr_en && cmd == lsr_pkg::CMD_THR_LOW |=> thr_lo == $past(wr_word))
    else $error("lower threshold write lost");
  psm_write_a: assert property (wr_en && cmd == lsr_pkg::CMD_PSM
    |=> power_saving_control == ($past(wr_word) & lsr_pkg::PSM_MASK)
    && ctrl_out.power_saving_enable == $past(wr_word[lsr_pkg::POWER_SAVING_ENABLE_BIT]))
    else $error("power saving write wrong");
  ambient_read_a: assert property (read_load(lsr_pkg::CMD_AMBIENT)
    |=> rd_word == $past(ambient) && tx_sh == rd_word[7:0] && state == lsr_pkg::ST_RDATA)
    else $error("ambient read word wrong");
  white_read_a: assert property (read_load(lsr_pkg::CMD_WHITE)
    |=> rd_word == $past(white) && tx_sh == rd_word[7:0])
    else $error("white read word wrong");
  hold_shutdown_a: assert property (ctrl_out.shutdown_control |=> $stable(ambient) && $stable(white))
    else $error("result changed during shutdown");
  low_flag_set_a: assert property (low_hit |=> low_flag ##1 1)
    else $error("low crossing flag not set");
  high_flag_set_a: assert property (high_hit |=> high_flag)
    else $error("high crossing flag not set");
  status_ro_a: assert property (wr_en && cmd == lsr_pkg::CMD_STATUS && !low_hit && !high_hit
    |=> $stable(low_flag) && $stable(high_flag))
    else $error("status changed by a write");
  irq_off_a: assert property (!conf[lsr_pkg::CONF_INT_EN_BIT] |=> !low_hit && !high_hit)
    else $error("crossing flagged while disabled");

endmodule

//--- testbench/lsr_i2c_host.sv
module lsr_i2c_host (
  input wire logic ref_clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask

  // Open drain: only ever pulls low, released otherwise
  task automatic xfer_bit(input logic b, output logic r);
    sda_low_out <= ~b;
    tick(4);
    scl_out <= 1'b1;
    tick(2);
    r = sda_in;
    tick(2);
    scl_out <= 1'b0;
    tick(1);
  endtask

  task automatic start_cond();
    sda_low_out <= 1'b0;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    sda_low_out <= 1'b1;
    tick(4);
    scl_out <= 1'b0;
    tick(1);
  endtask

  task automatic stop_cond();
    sda_low_out <= 1'b1;
    tick(4);
    scl_out <= 1'b1;
    tick(4);
    sda_low_out <= 1'b0;
    tick(4);
  endtask

  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], r);
    end
    xfer_bit(1'b1, r);
    ack = ~r;
  endtask

  task automatic read_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, d[i]);
    end
    xfer_bit(last, r);
  endtask

  task automatic probe(input logic [7:0] addr, output logic ack);
    start_cond();
    write_byte(addr, ack);
    stop_cond();
  endtask

  // Word goes out low byte first, always to the fixed target address
  task automatic reg_write(input logic [7:0] cmd, input logic [15:0] data, output logic ok);
    logic [3:0] a;
    start_cond();
    write_byte({lsr_pkg::TARGET_ADDR, 1'b0}, a[0]);
    write_byte(cmd, a[1]);
    write_byte(data[7:0], a[2]);
    write_byte(data[15:8], a[3]);
    stop_cond();
    ok = &a;
  endtask

  // Bus read sequence: command, repeated start, read address, two bytes
  task automatic reg_read(input logic [7:0] cmd, output logic [15:0] data, output logic ok);
    logic [2:0] a;
    start_cond();
    write_byte({lsr_pkg::TARGET_ADDR, 1'b0}, a[0]);
    write_byte(cmd, a[1]);
    start_cond();
    write_byte({lsr_pkg::TARGET_ADDR, 1'b1}, a[2]);
    read_byte(1'b0, data[7:0]);
    read_byte(1'b1, data[15:8]);
    stop_cond();
    ok = &a;
  endtask
endmodule

//--- testbench/lsr_sensor_regs_tb.sv
module lsr_sensor_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk_in;
  logic sys_rst_in;
  logic scl;
  logic host_low;
  logic sda_wire;
  logic sda_out;
  logic sda_oe_out;
  logic sample_valid_in;
  lsr_pkg::lsr_sample_s sample_in;
  lsr_pkg::lsr_ctrl_s ctrl_out;
  int miscompares;
  int comparisons;
  logic ok;
  logic [15:0] rd;

  // Wired-AND of both open-drain parties, pulled up otherwise
  assign sda_wire = ~(sda_oe_out | host_low);

  lsr_i2c_host host (
    .ref_clk_in(ref_clk_in),
    .sda_in(sda_wire),
    .scl_out(scl),
    .sda_low_out(host_low)
  );

  lsr_sensor_regs uut (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .scl_in(scl),
    .sda_in(sda_wire),
    .sda_out(sda_out),
    .sda_oe_out(sda_oe_out),
    .sample_valid_in(sample_valid_in),
    .sample_in(sample_in),
    .ctrl_out(ctrl_out)
  );

  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
    host.reg_write(cmd, data, ok);
    check("write ack", {15'h0000, ok}, 16'h0001);
  endtask

  task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp);
    host.reg_read(cmd, rd, ok);
    check("read ack", {15'h0000, ok}, 16'h0001);
    check($sformatf("reg %h", cmd), rd, exp);
  endtask

  task automatic pulse(input logic [15:0] amb, input logic [15:0] wht);
    sample_in <= '{ambient: amb, white: wht};
    sample_valid_in <= 1'b1;
    @(posedge ref_clk_in);
    sample_valid_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
  endtask

  // Guards against a hung bus walk
  initial begin
    repeat (100000) @(posedge ref_clk_in);
    miscompares++;
    results();
  end

  initial begin
    miscompares = 0;
    comparisons = 0;
    sys_rst_in = 1'b1;
    sample_valid_in = 1'b0;
    sample_in = '0;
    repeat (3) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    check("ctrl reset", {6'h00, ctrl_out}, 16'h0001);
    check("sda idle", {14'h0000, sda_out, sda_oe_out}, 16'h0000);
    rd_chk(lsr_pkg::CMD_THR_HIGH, 16'hFFFF);
    rd_chk(lsr_pkg::CMD_AMBIENT, 16'h0000);
    host.probe(8'h22, ok);
    check("foreign address ack", {15'h0000, ok}, 16'h0000);
    wr(lsr_pkg::CMD_THR_HIGH, 16'h1234);
    rd_chk(lsr_pkg::CMD_THR_HIGH, 16'h1234);
    wr(lsr_pkg::CMD_THR_LOW, 16'h0ABC);
    rd_chk(lsr_pkg::CMD_THR_LOW, 16'h0ABC);
    // Reserved bits 15:3 sent as zero in the sweep, then all set by 16'hFFFF to check the mask
    for (int m = 0; m < 8; m++) begin
      wr(lsr_pkg::CMD_PSM, {13'h0000, m[2:0]});
      check("psm mode", {14'h0000, ctrl_out.power_saving_mode_select}, {14'h0000, m[2:1]});
      check("psm enable", {15'h0000, ctrl_out.power_saving_enable}, {15'h0000, m[0]});
    end
    wr(lsr_pkg::CMD_PSM, 16'hFFFF);
    rd_chk(lsr_pkg::CMD_PSM, 16'h0007);
    // Gain 01 and integration 0001 awake; power saving still mode 4, enabled
    wr(lsr_pkg::CMD_CONF, 16'h0840);
    check("ctrl awake", {6'h00, ctrl_out}, 16'h011E);
    pulse(16'hA55A, 16'h5AA5);
    rd_chk(lsr_pkg::CMD_AMBIENT, 16'hA55A);
    rd_chk(lsr_pkg::CMD_WHITE, 16'h5AA5);
    wr(lsr_pkg::CMD_CONF, 16'h0001);
    pulse(16'h1111, 16'h2222);
    rd_chk(lsr_pkg::CMD_AMBIENT, 16'hA55A);
    wr(lsr_pkg::CMD_CONF, 16'h0000);
    pulse(16'h1111, 16'h2222);
    rd_chk(lsr_pkg::CMD_AMBIENT, 16'h1111);
    // Persistence of two: an in-window sample must restart the count
    wr(lsr_pkg::CMD_CONF, 16'h0012);
    pulse(16'h2000, 16'h0000);
    pulse(16'h0C00, 16'h0000);
    pulse(16'h2000, 16'h0000);
    rd_chk(lsr_pkg::CMD_STATUS, 16'h0000);
    pulse(16'h2000, 16'h0000);
    rd_chk(lsr_pkg::CMD_STATUS, 16'h4000);
    rd_chk(lsr_pkg::CMD_STATUS, 16'h0000);
    pulse(16'h0100, 16'h0000);
    pulse(16'h0100, 16'h0000);
    rd_chk(lsr_pkg::CMD_STATUS, 16'h8000);
    wr(lsr_pkg::CMD_CONF, 16'h0002);
    pulse(16'h0100, 16'h0000);
    rd_chk(lsr_pkg::CMD_STATUS, 16'h8000);
    wr(lsr_pkg::CMD_CONF, 16'h0000);
    pulse(16'h0100, 16'h0000);
    pulse(16'h2000, 16'h0000);
    rd_chk(lsr_pkg::CMD_STATUS, 16'h0000);
    // Persistence of eight, then lowered to one while a count is open
    wr(lsr_pkg::CMD_CONF, 16'h0032);
    repeat (7) pulse(16'h2000, 16'h0000);
    rd_chk(lsr_pkg::CMD_STATUS, 16'h0000);
    pulse(16'h2000, 16'h0000);
    rd_chk(lsr_pkg::CMD_STATUS, 16'h4000);
    repeat (3) pulse(16'h2000, 16'h0000);
    wr(lsr_pkg::CMD_CONF, 16'h0002);
    pulse(16'h2000, 16'h0000);
    rd_chk(lsr_pkg::CMD_STATUS, 16'h4000);
    wr(lsr_pkg::CMD_CONF, 16'h0002);
    pulse(16'h2000, 16'h0000);
    wr(lsr_pkg::CMD_STATUS, 16'h0000);
    rd_chk(lsr_pkg::CMD_STATUS, 16'h4000);
    results();
  end
endmodule
